/* File: phy_ability_regs.sv */
// per-port phy advertisement, partner ability and cable test start registers
`timescale 1ns/10ps

// Summary of operation
// RULE_01: advertisement bit 8 is read/write, resets to 1 and offers 100 full duplex.
// RULE_02: advertisement bit 7 is read/write, resets to 1 and offers 100 half duplex.
// RULE_03: advertisement bit 6 is read/write, resets to 1 and offers 10 full duplex.
// RULE_04: advertisement bit 5 is read/write, resets to 1 and offers 10 half duplex.
// RULE_05: advertisement bits 4 to 0 are read-only and always read 00001.
// RULE_06: partner bit 10 resets to 0 and follows the partner's pause ability.
// RULE_07: partner bit 8 resets to 0 and follows the partner's 100 full ability.
// RULE_08: partner bit 7 resets to 0 and follows the partner's 100 half ability.
// RULE_09: partner bit 6 resets to 0 and follows the partner's 10 full ability.
// RULE_10: partner bit 5 resets to 0 and follows the partner's 10 half ability.
// RULE_11: writing 1 to cable test bit 15 starts a test; the bit resets to 0.
// RULE_12: the start bit clears itself when the test finishes.
// RULE_13: software reads the test results only after the start bit reads 0.
// RULE_14: advertisement bit 10 is read/write, resets to 1 and offers pause.
// RULE_15: ability bits feed the sent base page; partner bits load from the received page.
module phy_ability_regs #(
  parameter int ADDR_W = phy_regs_pkg::REG_AW, // management address width
  parameter int DATA_W = phy_regs_pkg::DATA_W  // register width
) (
  input  wire logic              MCLK,          // system clock, 10 mhz
  input  wire logic              NRST,          // async reset, active low
  input  wire logic              REG_WR,        // management write strobe
  input  wire logic              REG_RD,        // management read strobe
  input  wire logic [ADDR_W-1:0] REG_ADDR,      // register address
  input  wire logic [DATA_W-1:0] REG_WDATA,     // write data
  output logic      [DATA_W-1:0] REG_RDATA,     // read data, registered
  output logic      [DATA_W-1:0] TX_BASE_PAGE,  // base page to send
  input  wire logic [DATA_W-1:0] RX_BASE_PAGE,  // base page received
  input  wire logic              RX_PAGE_VALID, // pulse: received page valid
  output logic                   TEST_START,    // pulse: cable test begins
  input  wire logic              TEST_DONE      // pulse: cable test finished
);

  typedef struct packed {
    logic [15:0] adv;
    logic [15:0] partner;
    logic        start;
    logic        start_pulse;
    logic [15:0] rdata;
  } state_s;

  state_s s_q;
  state_s s_d;

  // logic below serves only the standard register format
  if (ADDR_W != phy_regs_pkg::REG_AW) begin : g_bad_addr_w
    $error("register address width must be 5");
  end
  if (DATA_W != phy_regs_pkg::DATA_W) begin : g_bad_data_w
    $error("register data width must be 16");
  end

  function automatic logic [15:0] adv_value(input logic [15:0] ctrl);
    logic [15:0] v;
    v = phy_regs_pkg::ZERO16;
    v[phy_regs_pkg::ADV_RSVD_HI:phy_regs_pkg::ADV_RSVD_LO] = phy_regs_pkg::ADV_RSVD_VAL;
    v = v | (ctrl & phy_regs_pkg::ADV_CTRL_MASK);
    // RULE_05 fixed selector
    v[phy_regs_pkg::SEL_HI:0] = phy_regs_pkg::SELECTOR_VAL;
    return v;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.start_pulse = 1'b0;
    // RULE_01 RULE_02 RULE_03 RULE_04 RULE_14 writable abilities
    if (REG_WR && REG_ADDR == phy_regs_pkg::ADV_ADDR) begin
      s_d.adv = REG_WDATA & phy_regs_pkg::ADV_CTRL_MASK;
    end
    // RULE_06 RULE_07 RULE_08 RULE_09 RULE_10 RULE_15 partner capture
    if (RX_PAGE_VALID) begin
      s_d.partner = RX_BASE_PAGE & phy_regs_pkg::PARTNER_MASK;
    end
    // RULE_12 self clear on finish
    if (TEST_DONE) begin
      s_d.start = 1'b0;
    end
    // RULE_11 software start
    if (REG_WR && REG_ADDR == phy_regs_pkg::CABLE_ADDR) begin
      if (REG_WDATA[phy_regs_pkg::START_BIT] && !s_q.start) begin
        s_d.start = 1'b1;
        s_d.start_pulse = 1'b1;
      end else if (!REG_WDATA[phy_regs_pkg::START_BIT]) begin
        s_d.start = s_d.start;
      end
    end
    if (REG_RD) begin
      case (REG_ADDR)
        phy_regs_pkg::ADV_ADDR: begin
          s_d.rdata = adv_value(s_q.adv);
        end
        phy_regs_pkg::PARTNER_ADDR: begin
          s_d.rdata = s_q.partner | 16'(phy_regs_pkg::PARTNER_LOW_VAL);
        end
        phy_regs_pkg::CABLE_ADDR: begin
          // RULE_13 start bit tells software when results are valid
          s_d.rdata = phy_regs_pkg::ZERO16;
          s_d.rdata[phy_regs_pkg::START_BIT] = s_q.start;
        end
        default: begin
          s_d.rdata = phy_regs_pkg::ZERO16;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      s_q.adv         <= phy_regs_pkg::ADV_CTRL_RESET;
      s_q.partner     <= phy_regs_pkg::ZERO16;
      s_q.start       <= 1'b0;
      s_q.start_pulse <= 1'b0;
      s_q.rdata       <= phy_regs_pkg::ZERO16;
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA    = s_q.rdata;
  // RULE_15 base page from advertisement
  assign TX_BASE_PAGE = adv_value(s_q.adv);
  assign TEST_START   = s_q.start_pulse;

  // RULE_01 write lands
  property p_adv_write;
    @(posedge MCLK) disable iff (!NRST)
      (REG_WR && REG_ADDR == phy_regs_pkg::ADV_ADDR) |=>
        TX_BASE_PAGE[8:5] == $past(REG_WDATA[8:5]);
  endproperty
  a_adv_write: assert property (p_adv_write) else $error("adv bits not written"); // RULE_01

  // RULE_14 pause writable
  property p_adv_pause;
    @(posedge MCLK) disable iff (!NRST)
      (REG_WR && REG_ADDR == phy_regs_pkg::ADV_ADDR) |=> TX_BASE_PAGE[10] == $past(REG_WDATA[10]);
  endproperty
  a_adv_pause: assert property (p_adv_pause) else $error("pause bit not written"); // RULE_14

  // RULE_05 fixed selector
  property p_selector;
    @(posedge MCLK) disable iff (!NRST)
      TX_BASE_PAGE[phy_regs_pkg::SEL_HI:0] == phy_regs_pkg::SELECTOR_VAL;
  endproperty
  a_selector: assert property (p_selector) else $error("selector not 00001"); // RULE_05

  // RULE_02 readback matches
  property p_adv_read;
    @(posedge MCLK) disable iff (!NRST)
      (REG_RD && REG_ADDR == phy_regs_pkg::ADV_ADDR) |=> REG_RDATA == $past(TX_BASE_PAGE);
  endproperty
  a_adv_read: assert property (p_adv_read) else $error("adv readback wrong"); // RULE_02

  // RULE_07 partner capture
  property p_partner;
    @(posedge MCLK) disable iff (!NRST)
      RX_PAGE_VALID |=> s_q.partner == ($past(RX_BASE_PAGE) & phy_regs_pkg::PARTNER_MASK);
  endproperty
  a_partner: assert property (p_partner) else $error("partner capture wrong"); // RULE_07

  // RULE_11 single start pulse
  property p_start_pulse;
    @(posedge MCLK) disable iff (!NRST)
      $rose(s_q.start) |-> TEST_START ##1 !TEST_START;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse wrong"); // RULE_11

  // RULE_12 self clear
  property p_self_clear;
    @(posedge MCLK) disable iff (!NRST)
      (TEST_DONE && !(REG_WR && REG_ADDR == phy_regs_pkg::CABLE_ADDR)) |=> !s_q.start;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("start not cleared"); // RULE_12

  // RULE_13 start readback
  property p_start_read;
    @(posedge MCLK) disable iff (!NRST)
      (REG_RD && REG_ADDR == phy_regs_pkg::CABLE_ADDR) |=>
        REG_RDATA == {$past(s_q.start), 15'h0000};
  endproperty
  a_start_read: assert property (p_start_read) else $error("start readback wrong"); // RULE_13

  // RULE_11 restart refused
  property p_restart_ignored;
    @(posedge MCLK) disable iff (!NRST)
      (REG_WR && REG_ADDR == phy_regs_pkg::CABLE_ADDR && s_q.start) |=> !TEST_START;
  endproperty
  a_restart_ignored: assert property (p_restart_ignored) else $error("restart pulsed"); // RULE_11

  // RULE_11 zero keeps running
  property p_zero_keeps;
    @(posedge MCLK) disable iff (!NRST)
      (REG_WR && REG_ADDR == phy_regs_pkg::CABLE_ADDR && !REG_WDATA[phy_regs_pkg::START_BIT]
        && s_q.start && !TEST_DONE) |=> s_q.start;
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write stopped test"); // RULE_11

  // RULE_15 fixed page bits
  property p_adv_rsvd;
    @(posedge MCLK) disable iff (!NRST)
      !TX_BASE_PAGE[phy_regs_pkg::ADV9_BIT] &&
        (TX_BASE_PAGE[phy_regs_pkg::ADV_RSVD_HI:phy_regs_pkg::ADV_RSVD_LO] ==
         phy_regs_pkg::ADV_RSVD_VAL);
  endproperty
  a_adv_rsvd: assert property (p_adv_rsvd) else $error("fixed page bits wrong"); // RULE_15

  // RULE_10 partner low bits
  property p_partner_low;
    @(posedge MCLK) disable iff (!NRST)
      (REG_RD && REG_ADDR == phy_regs_pkg::PARTNER_ADDR) |=>
        REG_RDATA[phy_regs_pkg::SEL_HI:0] == phy_regs_pkg::PARTNER_LOW_VAL;
  endproperty
  a_partner_low: assert property (p_partner_low) else $error("partner low bits wrong"); // RULE_10

  c_start:   cover property (@(posedge MCLK) disable iff (!NRST) TEST_START ##[1:20] TEST_DONE);
  c_partner: cover property (@(posedge MCLK) disable iff (!NRST) RX_PAGE_VALID);
  c_adv:     cover property (@(posedge MCLK) disable iff (!NRST)
                 REG_WR && REG_ADDR == phy_regs_pkg::ADV_ADDR && REG_WDATA[8:5] == 4'h0);
  c_clear:   cover property (@(posedge MCLK) disable iff (!NRST) $fell(s_q.start));

endmodule // phy_ability_regs

/* File: phy_regs_pkg.sv */
// register map, field positions and reset values of the phy ability and cable test registers
package phy_regs_pkg;
  localparam int          REG_AW          = 5;
  localparam int          DATA_W          = 16;
  localparam logic [4:0]  ADV_ADDR        = 5'h04;
  localparam logic [4:0]  PARTNER_ADDR    = 5'h05;
  localparam logic [4:0]  CABLE_ADDR      = 5'h1d;
  localparam int          PAUSE_BIT       = 10;
  localparam int          ADV9_BIT        = 9;
  localparam int          F100_BIT        = 8;
  localparam int          H100_BIT        = 7;
  localparam int          F10_BIT         = 6;
  localparam int          H10_BIT         = 5;
  localparam int          START_BIT       = 15;
  localparam int          ADV_RSVD_HI     = 12;
  localparam int          ADV_RSVD_LO     = 11;
  localparam int          SEL_HI          = 4;
  localparam logic [4:0]  SELECTOR_VAL    = 5'h01;
  localparam logic [1:0]  ADV_RSVD_VAL    = 2'h1;
  localparam logic [4:0]  PARTNER_LOW_VAL = 5'h01;
  localparam logic [15:0] ADV_CTRL_MASK   = 16'h05e0;
  localparam logic [15:0] ADV_CTRL_RESET  = 16'h05e0;
  localparam logic [15:0] PARTNER_MASK    = 16'h05e0;
  localparam logic [15:0] ZERO16          = 16'h0000;
endpackage

/* File: far_side_model.sv */
// far side model: link partner base pages and cable test engine
`timescale 1ns/10ps
module far_side_model #(
  parameter int DELAY = 12
) (
  input  wire logic        MCLK,          // system clock
  input  wire logic        TEST_START,    // test begin pulse
  output logic      [15:0] RX_BASE_PAGE,  // page from partner
  output logic             RX_PAGE_VALID, // page valid pulse
  output logic             TEST_DONE      // test end pulse
);
  initial begin
    RX_BASE_PAGE  = 16'h0000;
    RX_PAGE_VALID = 1'b0;
    TEST_DONE     = 1'b0;
  end
  task automatic send_page(input logic [15:0] pg);
    @(posedge MCLK);
    RX_BASE_PAGE  <= pg;
    RX_PAGE_VALID <= 1'b1;
    @(posedge MCLK);
    RX_PAGE_VALID <= 1'b0;
    // released page no longer shows last value
    RX_BASE_PAGE  <= ~pg;
  endtask
  always @(posedge MCLK) begin
    if (TEST_START === 1'b1) begin
      repeat (DELAY) @(posedge MCLK);
      TEST_DONE <= 1'b1;
      @(posedge MCLK);
      TEST_DONE <= 1'b0;
    end
  end
endmodule // far_side_model

/* File: phy_ability_regs_tb.sv */
// self-checking bench of the phy ability and cable test registers
`timescale 1ns/10ps
module phy_ability_regs_tb;
  logic MCLK, NRST = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, RX_PAGE_VALID, TEST_START, TEST_DONE;
  logic [4:0]  REG_ADDR = 5'h00;
  logic [15:0] REG_WDATA = 16'h0000, REG_RDATA, TX_BASE_PAGE, RX_BASE_PAGE, d, v;
  int n_mismatch = 0, checks_done = 0, i;
  phy_ability_regs phy_ability_regs_inst (.*);
  far_side_model far_side_model_inst (.*);
  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end
  function automatic logic [15:0] expv(input logic [15:0] x, m, o);
    return (x & m) | o;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] x);
    @(posedge MCLK);
    REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= x;
    @(posedge MCLK);
    REG_WR <= 1'b0; REG_WDATA <= ~x;
    @(negedge MCLK);
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] x);
    @(posedge MCLK);
    REG_RD <= 1'b1; REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    @(negedge MCLK);
    x = REG_RDATA;
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(80));
    repeat (16) @(posedge MCLK);
    NRST <= 1'b1;
    rd(phy_regs_pkg::ADV_ADDR, v); chk("adv reset", 16'h0de1, v);
    chk("tx page reset", 16'h0de1, TX_BASE_PAGE);
    rd(phy_regs_pkg::PARTNER_ADDR, v); chk("partner reset", 16'h0001, v);
    rd(phy_regs_pkg::CABLE_ADDR, v); chk("cable reset", 16'h0000, v);
    for (i = 0; i < 12; i++) begin
      d = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom);
      wr(phy_regs_pkg::ADV_ADDR, d);
      chk("tx page", expv(d, 16'h05e0, 16'h0801), TX_BASE_PAGE);
      rd(phy_regs_pkg::ADV_ADDR, v); chk("adv", expv(d, 16'h05e0, 16'h0801), v);
      far_side_model_inst.send_page(~d);
      wr(phy_regs_pkg::PARTNER_ADDR, d);
      rd(phy_regs_pkg::PARTNER_ADDR, v); chk("partner", expv(~d, 16'h05e0, 16'h0001), v);
    end
    rd(5'h10, v); chk("unmapped", 16'h0000, v);
    wr(phy_regs_pkg::CABLE_ADDR, 16'h8000); chk("start pulse", 16'h0001, 16'(TEST_START));
    @(negedge MCLK); chk("start pulse end", 16'h0000, 16'(TEST_START));
    wr(phy_regs_pkg::CABLE_ADDR, 16'h8000); chk("restart ignored", 16'h0000, 16'(TEST_START));
    rd(phy_regs_pkg::CABLE_ADDR, v); chk("running", 16'h8000, v);
    wr(phy_regs_pkg::CABLE_ADDR, 16'h0000);
    rd(phy_regs_pkg::CABLE_ADDR, v); chk("zero write keeps", 16'h8000, v);
    v = 16'h8000;
    // wait for self clear before reading results
    for (i = 0; i < 40 && v[15] !== 1'b0; i++) rd(phy_regs_pkg::CABLE_ADDR, v);
    chk("self clear", 16'h0000, v);
    // mid-run reset after state was changed
    wr(phy_regs_pkg::ADV_ADDR, 16'h0000);
    far_side_model_inst.send_page(16'hffff);
    @(posedge MCLK);
    NRST <= 1'b0;
    @(posedge MCLK);
    NRST <= 1'b1;
    rd(phy_regs_pkg::ADV_ADDR, v); chk("adv after reset", 16'h0de1, v);
    chk("tx page after reset", 16'h0de1, TX_BASE_PAGE);
    rd(phy_regs_pkg::PARTNER_ADDR, v); chk("partner after reset", 16'h0001, v);
    tally_and_finish();
  end
endmodule // phy_ability_regs_tb
